// ===== lmsc_pkg.sv
// Package with constants and carrier types of the LIN mode serial controller.
// Behaviour
// - Master mode: send break drives thirteen low bits on the transmit line.
// - Master mode baud comes from conventional and extended prescalers.
// - Slave mode: send break does nothing to the transmit line.
// - Slave mode: LIN divider clocks both transmitter and receiver.
// - Detect method clear: break gives 00h data, receive full and header flags.
// - Header interrupt needs header enable and both CPU mask bits clear.
// - Auto sync measures synch field; otherwise synch is an ordinary character.
// - Detect method set: flags rise after whole header, identifier in data.
// - During synch measurement receiver is halted, nothing reaches data register.
// - Slave mode: framing error set for any framing error except a 00h character with low stop bit, as in a break.
// - Parity check tests identifier top two bits, third character from break.
// - Bad header sets header error; interrupt if receive enable and masks clear.
// - Blocked receiver stays blocked until software clears blocked, then error.
// - Header error clears by status access followed by data read.
// - No auto sync: error on synch not 55h, overrun, timeout with detect set.
// - Auto sync: error on deviation, timeout with detect set, overflow blocking, overrun off synch.
// - First deviation check: error above 16.40625 percent, never below 15.625.
// - Per-bit check against current bit time; deviation error sets blocked flag.
// - Header not done within 57 bit times sets header error when detect method is set.
// - Slave rate is clock over sixteen times divider, 8.4 fixed point.
// - Timeout counter restarts at break, stops at identifier or any header error except overrun.
package lmsc_pkg;
  localparam logic [7:0] SYNCH_CHAR = 8'h55;
  localparam logic [7:0] BREAK_CHAR = 8'h00;
  localparam int BREAK_BITS = 13;
  localparam int HDR_TIMEOUT_BITS = 57;
  localparam int OVERSAMPLE = 16;
  localparam int BRK_DETECT_BITS = 11;
  localparam logic [11:0] LIN_DIVIDER_RESET = 12'h000;
  // Deviation limit as 64ths of the nominal measurement: 10/64 = 15.625 percent.
  localparam int DEV_NUM = 10;
  localparam int DEV_DEN_SHIFT = 6;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_DATA = 3'b001,
    RX_STOP = 3'b010,
    RX_SYNC = 3'b011,
    RX_BLOCK = 3'b100
  } lmsc_rx_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_BREAK = 2'b10
  } lmsc_tx_t;

  typedef struct packed {
    logic linEnable;
    logic linSlaveSelect;
    logic headerDetectMethod;
    logic autoSyncEnable;
    logic idParityCheckEnable;
    logic headerInterruptEnable;
    logic receiveInterruptEnable;
    logic sendBreak;
    logic [1:0] cpuMask;
  } lmsc_ctrl_t;

  typedef struct packed {
    logic rxDataFullFlag;
    logic txDataEmptyFlag;
    logic headerDetectedFlag;
    logic headerErrorFlag;
    logic synchBlockedFlag;
    logic framingErrorFlag;
    logic overrunFlag;
    logic parityErrorFlag;
  } lmsc_status_t;
endpackage

// ===== lin_mode_serial_controller.sv
// LIN mode serial controller: transmitter, receiver, header logic and baud generation.
`timescale 1ns/1ps
module lmsc_lin_mode_serial_controller #(
  parameter int MEAS_W = 15
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // Control
  input wire lmsc_pkg::lmsc_ctrl_t ctrl,
  input wire logic [7:0] baudPrescaleDiv,
  input wire logic [7:0] extPrescale,
  input wire logic [7:0] linPrescalerMantissa,
  input wire logic [3:0] linPrescalerFraction,
  input wire logic linPrescalerWrite,
  // Data access
  input wire logic [7:0] txData,
  input wire logic txWrite,
  input wire logic statusAccess,
  input wire logic dataRead,
  input wire logic clearSynchBlocked,
  // Line
  input wire logic receiveInputPin,
  output logic txPin,
  // Status
  output logic [7:0] serialDataReg,
  output lmsc_pkg::lmsc_status_t status,
  output logic [11:0] linDivider,
  output logic headerIrq,
  output logic receiveIrq
);
  typedef struct packed {
    logic [2:0] rxSync;
    logic rxLine;
    lmsc_pkg::lmsc_rx_t rxState;
    logic [3:0] rxBit;
    logic [7:0] rxShift;
    logic [4:0] lowBits;
    logic [1:0] charCount;
    logic headerActive;
    logic [6:0] hdrBits;
    logic [2:0] edgeCount;
    logic [MEAS_W-1:0] meas;
    logic [MEAS_W-1:0] bitMeas;
    logic bitTooShort;
    lmsc_pkg::lmsc_tx_t txState;
    logic [8:0] txShift;
    logic [3:0] txBit;
    logic txPending;
    logic [7:0] txHold;
    logic [16:0] baudCnt;
    logic [3:0] fracAcc;
    logic [3:0] tick16;
    logic [3:0] rxTick16;
    logic statusSeen;
    logic blockedClearSeen;
    logic [7:0] dataReg;
    lmsc_pkg::lmsc_status_t st;
    logic [11:0] lin_divider;
    logic txOut;
    logic hIrq;
    logic rIrq;
  } lmsc_state_t;

  lmsc_state_t s;
  lmsc_state_t next_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic baudTick;
    logic slave;
    logic [16:0] period;
    logic rxSample;
    logic fall;
    logic brk;
    logic headerErr;
    logic [MEAS_W+1:0] nominal;
    logic [MEAS_W+1:0] diff;
    logic [11:0] measDiv;
    logic [4:0] fracSum;
    baudTick = 1'b0;
    period = 17'h00000;
    nominal = '0;
    diff = '0;
    measDiv = 12'h000;
    fracSum = {1'b0, s.fracAcc} + {1'b0, s.lin_divider[3:0]};
    brk = 1'b0;
    headerErr = 1'b0;
    rxSample = 1'b0;
    next_s = s;
    slave = ctrl.linEnable & ctrl.linSlaveSelect;
    next_s.rxSync = {s.rxSync[1:0], receiveInputPin};
    if (s.rxSync[2] == s.rxSync[1])
    begin
      next_s.rxLine = s.rxSync[2];
    end
    fall = s.rxLine & ~next_s.rxLine;
    // Sixteen-times oversampling tick source.
    if (slave)
    begin
      // Mantissa clocks per tick, one more whenever the fraction accumulator carries.
      period = (s.lin_divider[11:4] == 8'h00) ? 17'h00000 :
        {9'h000, s.lin_divider[11:4]} + {16'h0000, fracSum[4]} - 17'h00001;
    end
    else
    begin
      period = {9'h000, baudPrescaleDiv} * {9'h000, (extPrescale == 8'h00) ? 8'h01 : extPrescale};
    end
    if (s.baudCnt >= period)
    begin
      baudTick = 1'b1;
      next_s.baudCnt = 17'h00000;
      next_s.fracAcc = fracSum[3:0];
    end
    else
    begin
      next_s.baudCnt = s.baudCnt + 17'h00001;
    end
    if (baudTick)
    begin
      next_s.tick16 = s.tick16 + 4'h1;
      next_s.rxTick16 = s.rxTick16 + 4'h1;
      rxSample = (s.rxTick16 == 4'h8);
    end
    // Divider load from software has priority over a measured update.
    if (linPrescalerWrite)
    begin
      next_s.lin_divider = {linPrescalerMantissa, linPrescalerFraction};
    end
    // Transmitter.
    case (s.txState)
      lmsc_pkg::TX_IDLE:
      begin
        next_s.txOut = 1'b1;
        if (ctrl.sendBreak && ctrl.linEnable && !ctrl.linSlaveSelect)
        begin
          next_s.txState = lmsc_pkg::TX_BREAK;
          next_s.txOut = 1'b0;
          next_s.baudCnt = 17'h00000;
          next_s.txBit = 4'h0;
          next_s.tick16 = 4'h0;
        end
        else if (s.txPending && baudTick && s.tick16 == 4'hf)
        begin
          next_s.txShift = {1'b1, s.txHold};
          next_s.txOut = 1'b0;
          next_s.txPending = 1'b0;
          next_s.st.txDataEmptyFlag = 1'b1;
          next_s.txBit = 4'h0;
          next_s.txState = lmsc_pkg::TX_SHIFT;
        end
      end
      lmsc_pkg::TX_SHIFT:
      begin
        if (baudTick && s.tick16 == 4'hf)
        begin
          next_s.txOut = s.txShift[0];
          next_s.txShift = {1'b1, s.txShift[8:1]};
          next_s.txBit = s.txBit + 4'h1;
          if (s.txBit == 4'h9)
          begin
            next_s.txOut = 1'b1;
            next_s.txState = lmsc_pkg::TX_IDLE;
          end
        end
      end
      lmsc_pkg::TX_BREAK:
      begin
        next_s.txOut = 1'b0;
        if (baudTick && s.tick16 == 4'hf)
        begin
          next_s.txBit = s.txBit + 4'h1;
          if (s.txBit == 4'(lmsc_pkg::BREAK_BITS - 1))
          begin
            next_s.txOut = 1'b1;
            next_s.txState = lmsc_pkg::TX_IDLE;
          end
        end
      end
      default: next_s.txState = lmsc_pkg::TX_IDLE;
    endcase
    if (txWrite)
    begin
      next_s.txHold = txData;
      next_s.txPending = 1'b1;
      next_s.st.txDataEmptyFlag = 1'b0;
    end
    // Status access then data read clears overrun, framing, header detected and, unless blocked, header error; later sets in this cycle win.
    if (statusAccess)
    begin
      next_s.statusSeen = 1'b1;
    end
    if (dataRead)
    begin
      next_s.st.rxDataFullFlag = 1'b0;
      if (s.statusSeen)
      begin
        next_s.statusSeen = 1'b0;
        next_s.st.overrunFlag = 1'b0;
        next_s.st.framingErrorFlag = 1'b0;
        next_s.st.headerDetectedFlag = 1'b0;
        if (!s.st.synchBlockedFlag)
        begin
          next_s.st.headerErrorFlag = 1'b0;
          if (s.rxState == lmsc_pkg::RX_BLOCK && s.blockedClearSeen)
          begin
            next_s.rxState = lmsc_pkg::RX_IDLE;
            next_s.blockedClearSeen = 1'b0;
          end
        end
      end
    end
    // Header timeout counting in bit times.
    if (s.headerActive && baudTick && s.rxTick16 == 4'hf && (ctrl.headerDetectMethod || ctrl.autoSyncEnable))
    begin
      next_s.hdrBits = s.hdrBits + 7'h01;
      if (s.hdrBits == 7'(lmsc_pkg::HDR_TIMEOUT_BITS))
      begin
        next_s.headerActive = 1'b0;
        if (ctrl.headerDetectMethod)
        begin
          headerErr = 1'b1;
        end
        if (s.rxState == lmsc_pkg::RX_SYNC)
        begin
          next_s.st.synchBlockedFlag = ctrl.autoSyncEnable;
          next_s.rxState = ctrl.autoSyncEnable ? lmsc_pkg::RX_BLOCK : lmsc_pkg::RX_IDLE;
        end
      end
    end
    // Receiver.
    case (s.rxState)
      lmsc_pkg::RX_IDLE:
      begin
        if (fall)
        begin
          next_s.rxState = lmsc_pkg::RX_DATA;
          next_s.rxTick16 = 4'h0;
          next_s.rxBit = 4'h0;
          next_s.lowBits = 5'h00;
        end
      end
      lmsc_pkg::RX_DATA:
      begin
        if (rxSample)
        begin
          next_s.rxBit = s.rxBit + 4'h1;
          next_s.lowBits = s.rxLine ? 5'h00 : s.lowBits + 5'h01;
          if (s.rxBit != 4'h0)
          begin
            next_s.rxShift = {s.rxLine, s.rxShift[7:1]};
          end
          if (s.rxBit == 4'h8)
          begin
            next_s.rxState = lmsc_pkg::RX_STOP;
          end
        end
      end
      lmsc_pkg::RX_STOP:
      begin
        if (rxSample)
        begin
          next_s.lowBits = s.rxLine ? 5'h00 : s.lowBits + 5'h01;
          if (s.rxLine)
          begin
            next_s.rxState = lmsc_pkg::RX_IDLE;
            brk = slave && s.lowBits >= 5'(lmsc_pkg::BRK_DETECT_BITS);
            if (brk)
            begin
              next_s.headerActive = 1'b1;
              next_s.hdrBits = 7'h00;
              next_s.charCount = 2'h1;
              if (!ctrl.headerDetectMethod)
              begin
                next_s.dataReg = lmsc_pkg::BREAK_CHAR;
                next_s.st.rxDataFullFlag = 1'b1;
                next_s.st.headerDetectedFlag = 1'b1;
              end
              if (ctrl.autoSyncEnable)
              begin
                next_s.rxState = lmsc_pkg::RX_SYNC;
                next_s.edgeCount = 3'h0;
                next_s.meas = '0;
                next_s.bitMeas = '0;
                next_s.bitTooShort = 1'b0;
              end
            end
            else
            begin
              if (s.st.rxDataFullFlag && !(slave && s.charCount == 2'h1 && ctrl.autoSyncEnable))
              begin
                next_s.st.overrunFlag = 1'b1;
                headerErr = slave && s.headerActive;
              end
              if (slave && s.headerActive && s.charCount == 2'h1 && s.rxShift != lmsc_pkg::SYNCH_CHAR)
              begin
                headerErr = 1'b1;
                next_s.headerActive = 1'b0;
              end
              if (slave && s.headerActive && s.charCount == 2'h2)
              begin
                next_s.headerActive = 1'b0;
                next_s.st.headerDetectedFlag = 1'b1;
                if (ctrl.idParityCheckEnable)
                begin
                  next_s.st.parityErrorFlag =
                    (s.rxShift[6] != ^{s.rxShift[0], s.rxShift[1], s.rxShift[2], s.rxShift[4]}) ||
                    (s.rxShift[7] != ~^{s.rxShift[1], s.rxShift[3], s.rxShift[4], s.rxShift[5]});
                end
              end
              if (!(slave && ctrl.headerDetectMethod && s.headerActive && s.charCount != 2'h2))
              begin
                next_s.dataReg = s.rxShift;
                next_s.st.rxDataFullFlag = 1'b1;
              end
              if (s.headerActive)
              begin
                next_s.charCount = s.charCount + 2'h1;
              end
            end
          end
          else if (!slave || s.lowBits < 5'(lmsc_pkg::BRK_DETECT_BITS - 1))
          begin
            if (s.lowBits != 5'(lmsc_pkg::BRK_DETECT_BITS - 2) || !slave)
            begin
              next_s.st.framingErrorFlag = 1'b1;
            end
          end
        end
      end
      lmsc_pkg::RX_SYNC:
      begin
        next_s.meas = s.meas + 1'b1;
        next_s.bitMeas = s.bitMeas + 1'b1;
        if (&s.meas)
        begin
          headerErr = 1'b1;
          next_s.st.synchBlockedFlag = 1'b1;
          next_s.rxState = lmsc_pkg::RX_BLOCK;
          next_s.headerActive = 1'b0;
        end
        else if (fall)
        begin
          next_s.edgeCount = s.edgeCount + 3'h1;
          next_s.bitMeas = '0;
          // The measurement runs from the first falling edge of the synch field.
          if (s.edgeCount == 3'h0)
          begin
            next_s.meas = '0;
          end
          // Two bit times lie between successive falling edges of the synch field.
          if (s.edgeCount != 3'h0 && {5'h00, s.bitMeas, 4'h0} <
              ({{MEAS_W-7{1'b0}}, s.lin_divider, 4'h0} * 2'd2 * 6'(64 - lmsc_pkg::DEV_NUM)) >> 6)
          begin
            next_s.bitTooShort = 1'b1;
          end
          if (s.edgeCount == 3'h4)
          begin
            nominal = {{MEAS_W-10{1'b0}}, s.lin_divider} << 3;
            diff = (nominal > {2'b00, s.meas}) ? nominal - {2'b00, s.meas} : {2'b00, s.meas} - nominal;
            measDiv = 12'(s.meas >> 3);
            if (s.bitTooShort || (diff << lmsc_pkg::DEV_DEN_SHIFT) > nominal * lmsc_pkg::DEV_NUM)
            begin
              headerErr = 1'b1;
              next_s.st.synchBlockedFlag = 1'b1;
              next_s.rxState = lmsc_pkg::RX_BLOCK;
              next_s.headerActive = 1'b0;
            end
            else
            begin
              next_s.rxState = lmsc_pkg::RX_IDLE;
              next_s.charCount = 2'h2;
              if (!linPrescalerWrite)
              begin
                next_s.lin_divider = measDiv;
              end
            end
          end
        end
      end
      lmsc_pkg::RX_BLOCK:
      begin
        if (clearSynchBlocked)
        begin
          next_s.st.synchBlockedFlag = 1'b0;
          next_s.blockedClearSeen = 1'b1;
        end
      end
      default: next_s.rxState = lmsc_pkg::RX_IDLE;
    endcase
    if (headerErr)
    begin
      next_s.st.headerErrorFlag = 1'b1;
    end
    next_s.hIrq = next_s.st.headerDetectedFlag & ctrl.headerInterruptEnable & ~|ctrl.cpuMask;
    next_s.rIrq = (next_s.st.headerErrorFlag | next_s.st.rxDataFullFlag) &
      ctrl.receiveInterruptEnable & ~|ctrl.cpuMask;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.rxSync <= 3'h7;
      s.rxLine <= 1'b1;
      s.txOut <= 1'b1;
      s.lin_divider <= lmsc_pkg::LIN_DIVIDER_RESET;
      s.st.txDataEmptyFlag <= 1'b1;
    end
    else if (clkEn)
    begin
      s <= next_s;
    end
  end

  assign txPin = s.txOut;
  assign serialDataReg = s.dataReg;
  assign status = s.st;
  assign linDivider = s.lin_divider;
  assign headerIrq = s.hIrq;
  assign receiveIrq = s.rIrq;
endmodule // lmsc_lin_mode_serial_controller

// ===== lmsc_chk.sv
// Port checker of the LIN mode serial controller.
`timescale 1ns/1ps
module lmsc_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control and access
  input wire lmsc_pkg::lmsc_ctrl_t ctrl,
  input wire logic dataRead,
  input wire logic clearSynchBlocked,
  // Outputs
  input wire logic txPin,
  input wire logic [7:0] serialDataReg,
  input wire lmsc_pkg::lmsc_status_t status,
  input wire logic [11:0] linDivider,
  input wire logic headerIrq,
  input wire logic receiveIrq
);
  logic [15:0] lowRun;

  // ----------------------------------------
  // Low run counter of the transmit line.
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      lowRun <= 16'h0000;
    else if (txPin)
      lowRun <= 16'h0000;
    else if (lowRun != 16'hffff)
      lowRun <= lowRun + 16'h0001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_hdr_irq_gate: assert property (headerIrq |-> ctrl.headerInterruptEnable
    && ctrl.cpuMask == 2'b00 && status.headerDetectedFlag) else $error("header irq ungated");
  a_rx_irq_gate: assert property (receiveIrq |-> ctrl.receiveInterruptEnable
    && ctrl.cpuMask == 2'b00) else $error("receive irq ungated");
  a_slave_low_run: assert property (ctrl.linEnable && ctrl.linSlaveSelect && !txPin
    |-> int'(lowRun) <= 10 * int'(linDivider)) else $error("slave line low too long");
  a_break_data: assert property ($rose(status.headerDetectedFlag)
    && !ctrl.headerDetectMethod |-> status.rxDataFullFlag && serialDataReg == 8'h00)
    else $error("break without zero data");
  a_hdm_whole_hdr: assert property ($rose(status.headerDetectedFlag)
    && ctrl.headerDetectMethod |-> status.rxDataFullFlag) else $error("header without data");
  a_fe_not_break: assert property ($rose(status.headerDetectedFlag)
    && !ctrl.headerDetectMethod |-> !$rose(status.framingErrorFlag))
    else $error("framing error on break");
  a_block_holds: assert property (status.synchBlockedFlag && !clearSynchBlocked
    |=> status.synchBlockedFlag) else $error("block left without clear");
  a_err_while_blk: assert property (status.synchBlockedFlag && status.headerErrorFlag
    |=> status.headerErrorFlag) else $error("header error dropped while blocked");
  a_err_clear_rd: assert property ($fell(status.headerErrorFlag)
    |-> $past(dataRead)) else $error("header error cleared without data read");
  a_block_has_err: assert property ($rose(status.synchBlockedFlag)
    |-> ##[0:1] status.headerErrorFlag) else $error("block without header error");
  a_pe_needs_pce: assert property ($rose(status.parityErrorFlag)
    |-> ctrl.idParityCheckEnable) else $error("parity error while check off");
endmodule // lmsc_chk

bind lmsc_lin_mode_serial_controller lmsc_chk i_chk (.ref_clk(ref_clk), .nrst(nrst),
  .ctrl(ctrl), .dataRead(dataRead), .clearSynchBlocked(clearSynchBlocked), .txPin(txPin),
  .serialDataReg(serialDataReg), .status(status), .linDivider(linDivider),
  .headerIrq(headerIrq), .receiveIrq(receiveIrq));

// ===== lmsc_lin_node.sv
// Behavioural LIN master node that sends a header to the slave receive line.
`timescale 1ns/1ps
module lmsc_lin_node #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input wire logic ref_clk,
  // Header request
  input wire logic go,
  input wire logic [7:0] synchByte,
  input wire logic [7:0] synchClks,
  input wire logic [7:0] idByte,
  input wire logic [1:0] txMode,
  // Line
  output logic line
);
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic send_char(input logic [7:0] b, input int n, input logic stopBit);
    hold(1'b0, n);
    for (int i = 0; i < 8; i++)
      hold(b[i], n);
    hold(stopBit, n);
  endtask

  // Idle line is recessive high, as with the bus pull-up.
  initial
  begin
    line = 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (go === 1'b1)
      begin
        hold(1'b0, 13 * BIT_CLKS);
        hold(1'b1, BIT_CLKS);
        send_char(synchByte, int'(synchClks), 1'b1);
        if (txMode[1])
          send_char(idByte, BIT_CLKS, !txMode[0]);
        line <= 1'b1;
      end
    end
  end
endmodule // lmsc_lin_node

// ===== tb_top.sv
// Self-checking testbench of the LIN mode serial controller.
`timescale 1ns/1ps
module tb_top;
  localparam int BIT = 32;
  typedef struct packed {
    logic [5:0] cfg;
    logic [7:0] synch;
    logic [7:0] synchClks;
    logic [7:0] id;
    logic [1:0] txMode;
    logic [7:0] expSt;
    logic [7:0] stMask;
    logic [7:0] expData;
    logic chkData;
    logic [1:0] expIrq;
  } lmsc_row_t;
  // Config is header method, auto sync, header irq, receive irq, cpu mask.
  localparam lmsc_row_t ROWS [8] = '{
    '{6'b101000, 8'h55, 8'h20, 8'h80, 2'b10, 8'he0, 8'hff, 8'h80, 1'b1, 2'b10},
    '{6'b101101, 8'h55, 8'h20, 8'h00, 2'b10, 8'he1, 8'hef, 8'h00, 1'b1, 2'b00},
    '{6'b100100, 8'h54, 8'h20, 8'h80, 2'b10, 8'h10, 8'h10, 8'h00, 1'b0, 2'b01},
    '{6'b000000, 8'h55, 8'h20, 8'h80, 2'b10, 8'hf2, 8'hf6, 8'h00, 1'b0, 2'b00},
    '{6'b110000, 8'h55, 8'h20, 8'h80, 2'b10, 8'he0, 8'hff, 8'h80, 1'b1, 2'b00},
    '{6'b100000, 8'h55, 8'h20, 8'h80, 2'b00, 8'h10, 8'h10, 8'h00, 1'b0, 2'b00},
    '{6'b100000, 8'h55, 8'h20, 8'h80, 2'b11, 8'h04, 8'h04, 8'h00, 1'b0, 2'b00},
    '{6'b110000, 8'h55, 8'h18, 8'h80, 2'b10, 8'h18, 8'h18, 8'h00, 1'b0, 2'b00}
  };
  logic ref_clk, nrst, linPrescalerWrite, txWrite, statusAccess, dataRead, go;
  logic clearSynchBlocked, receiveInputPin, txPin, headerIrq, receiveIrq;
  lmsc_pkg::lmsc_ctrl_t ctrl;
  lmsc_pkg::lmsc_status_t status;
  logic [7:0] baudPrescaleDiv, linPrescalerMantissa, txData, serialDataReg;
  logic [7:0] synchByte, synchClks, idByte;
  logic [3:0] linPrescalerFraction;
  logic [11:0] linDivider;
  logic [1:0] txMode;
  int failures, nCompared, t, brk, lows;

  lmsc_lin_mode_serial_controller i_dut (.ref_clk(ref_clk), .nrst(nrst), .clkEn(1'b1),
    .ctrl(ctrl), .baudPrescaleDiv(baudPrescaleDiv), .extPrescale(8'h00),
    .linPrescalerMantissa(linPrescalerMantissa), .linPrescalerFraction(linPrescalerFraction),
    .linPrescalerWrite(linPrescalerWrite), .txData(txData), .txWrite(txWrite),
    .statusAccess(statusAccess), .dataRead(dataRead), .clearSynchBlocked(clearSynchBlocked),
    .receiveInputPin(receiveInputPin), .txPin(txPin), .serialDataReg(serialDataReg),
    .status(status), .linDivider(linDivider), .headerIrq(headerIrq), .receiveIrq(receiveIrq));
  lmsc_lin_node #(.BIT_CLKS(BIT)) i_node (.ref_clk(ref_clk), .go(go), .synchByte(synchByte),
    .synchClks(synchClks), .idByte(idByte), .txMode(txMode), .line(receiveInputPin));

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic measure_low(output int n);
    n = 0;
    for (int w = 0; w < 20000 && txPin !== 1'b0; w++)
      @(negedge ref_clk);
    while (txPin === 1'b0 && n < 20000)
    begin
      n++;
      @(negedge ref_clk);
    end
  endtask

  task automatic access;
    tick(1);
    statusAccess <= 1'b1;
    tick(1);
    statusAccess <= 1'b0;
    dataRead <= 1'b1;
    tick(1);
    dataRead <= 1'b0;
    tick(2);
    @(negedge ref_clk);
  endtask

  task automatic run_row(input lmsc_row_t r);
    tick(1);
    nrst <= 1'b0;
    ctrl <= '{1'b1, 1'b1, r.cfg[5], r.cfg[4], 1'b1, r.cfg[3], r.cfg[2], 1'b0, r.cfg[1:0]};
    tick(2);
    nrst <= 1'b1;
    tick(1);
    linPrescalerMantissa <= 8'h02;
    linPrescalerFraction <= 4'h0;
    linPrescalerWrite <= 1'b1;
    {synchByte, synchClks, idByte, txMode} <= {r.synch, r.synchClks, r.id, r.txMode};
    tick(1);
    linPrescalerWrite <= 1'b0;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(80 * BIT);
    @(negedge ref_clk);
    check("status", 16'(r.expSt & r.stMask), 16'(status & r.stMask));
    if (r.chkData)
      check("data", 16'(r.expData), 16'(serialDataReg));
    check("irq", 16'(r.expIrq), 16'({headerIrq, receiveIrq}));
  endtask

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and test sequence.
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial
  begin
    tick(40000);
    failures++;
    print_verdict();
  end

  initial
  begin
    {nrst, linPrescalerWrite, txWrite, statusAccess, dataRead, go, clearSynchBlocked} = '0;
    {ctrl, linPrescalerMantissa, linPrescalerFraction, txData, txMode} = '0;
    {synchByte, synchClks, idByte} = '0;
    baudPrescaleDiv = 8'h01;
    failures = 0;
    nCompared = 0;
    tick(4);
    nrst <= 1'b1;
    @(negedge ref_clk);
    check("reset outputs", 16'({8'h40, 1'b1, 2'b00}), 16'({status, txPin, headerIrq, receiveIrq}));
    check("reset divider", 16'h0000, 16'({linDivider, serialDataReg}));
    $display("test reset done");
    tick(1);
    ctrl.linEnable <= 1'b1;
    txData <= 8'hff;
    txWrite <= 1'b1;
    tick(1);
    txWrite <= 1'b0;
    measure_low(t);
    check("master bit seen", 16'h0001, 16'(t > 0));
    tick(12 * t);
    ctrl.sendBreak <= 1'b1;
    fork
      measure_low(brk);
      begin
        @(negedge txPin);
        tick(1);
        ctrl.sendBreak <= 1'b0;
      end
    join
    check("master break length", 16'(13 * t), 16'(brk));
    $display("test master break done");
    tick(12 * t);
    ctrl.linSlaveSelect <= 1'b1;
    linPrescalerMantissa <= 8'h02;
    linPrescalerFraction <= 4'h8;
    linPrescalerWrite <= 1'b1;
    tick(1);
    linPrescalerWrite <= 1'b0;
    txWrite <= 1'b1;
    tick(1);
    txWrite <= 1'b0;
    measure_low(t);
    check("slave bit length", 16'h0028, 16'(t));
    check("slave divider", 16'h0028, 16'(linDivider));
    tick(12 * 40);
    ctrl.sendBreak <= 1'b1;
    lows = 0;
    repeat (20 * 40)
    begin
      @(negedge ref_clk);
      if (txPin !== 1'b1)
        lows++;
    end
    check("slave break line", 16'h0000, 16'(lows));
    tick(1);
    ctrl.sendBreak <= 1'b0;
    $display("test slave transmit done");
    foreach (ROWS[i])
    begin
      run_row(ROWS[i]);
      $display("test header row %0d done", i);
    end
    access();
    check("blocked error held", 16'h0018, 16'(status & 8'h18));
    tick(1);
    clearSynchBlocked <= 1'b1;
    tick(1);
    clearSynchBlocked <= 1'b0;
    access();
    check("error cleared", 16'h0000, 16'(status & 8'h18));
    $display("test blocked recovery done");
    print_verdict();
  end
endmodule // tb_top
